// [verilog/pmt8_timer.v]
// Function
// - count up per prescaled tick; at period match next tick wraps to zero
// - period register 8 bits, read/write, reset to all ones
// - count register 8 bits, read/write, cleared by every reset
// - input is clock/4 then prescaler: 00 by 1, 01 by 4, 1x by 16
// - postscaler on matches, control bits 6:3, divides by code plus one
// - postscaler output sets sticky match flag bit 1 until software clears
// - prescaler and postscaler cleared by count write, control write, reset
// - control write leaves count value unchanged
// - control bit 2 runs timer; cleared stops counting
// - control bit 7 unimplemented, reads zero, writes ignored
// - pre-postscaler match pulse offered to serial port shift clock
// - match pulse and count serve as pwm time base for capture unit
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pmt8_consts.vh"
module pmt8_timer
(
  input  wire       clk,
  input  wire       reset_n,
  input  wire [4:0] avs_address,
  input  wire       avs_read,
  input  wire       avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0] avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg        avs_waitrequest,
  output reg        irq,
  output reg        match_pulse,
  output reg  [7:0] timer_count_out
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [7:0] timer_control_r;
  reg  [7:0] timer_count_r;
  reg  [7:0] period_value_r;
  reg  [7:0] status_r;
  reg  [7:0] mask_r;
  reg  [1:0] instr_div_r;
  reg  [3:0] pre_cnt_r;
  reg  [3:0] post_cnt_r;
  reg        ack_r;

  wire [2:0] idx      = avs_address[4:2];
  wire       low_lane = avs_byteenable[0];
  // one wait cycle per access; the access completes on the edge after ack_r rises
  wire       acc      = (avs_read | avs_write) & ~ack_r;
  wire       wr       = avs_write & ack_r & low_lane;
  wire       rd       = avs_read & ack_r;
  wire       wr_ctrl  = wr & (idx == `PMT8_IDX_CONTROL);
  wire       wr_count = wr & (idx == `PMT8_IDX_COUNT);
  wire       wr_per   = wr & (idx == `PMT8_IDX_PERIOD);
  wire       wr_mask  = wr & (idx == `PMT8_IDX_MASK);
  wire       rd_stat  = rd & (idx == `PMT8_IDX_STATUS);

  // ------------------------------------------------------------
  // tick chain
  // ------------------------------------------------------------
  wire [1:0] pre_sel  = timer_control_r[`PMT8_PRE_MSB:`PMT8_PRE_LSB];
  wire [3:0] post_sel = timer_control_r[`PMT8_POST_MSB:`PMT8_POST_LSB];
  wire       run      = timer_control_r[`PMT8_RUN_BIT];
  wire       instr_en = (instr_div_r == `PMT8_INSTR_DIV);
  reg  [3:0] pre_top;
  always @*
  begin
    case (pre_sel)
      2'h0:    pre_top = `PMT8_PRE_TOP_1;
      `PMT8_PRE_CODE_4: pre_top = `PMT8_PRE_TOP_4;
      default: pre_top = `PMT8_PRE_TOP_16;
    endcase
  end
  wire       pre_tick  = run & instr_en & (pre_cnt_r == pre_top);
  wire       match     = pre_tick & (timer_count_r == period_value_r);
  wire       post_tick = match & (post_cnt_r == post_sel);
  wire       clr_scale = wr_ctrl | wr_count;

  reg  [7:0] timer_count_nxt;
  always @*
  begin
    timer_count_nxt = timer_count_r;
    if (match)
      timer_count_nxt = `PMT8_COUNT_RST;
    else if (pre_tick)
      timer_count_nxt = timer_count_r + 8'h01;
    if (wr_count)
      timer_count_nxt = avs_writedata[7:0];
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped words read as zero and swallow writes
  reg  [7:0] read_mux;
  always @*
  begin
    read_mux = 8'h00;
    case (idx)
      `PMT8_IDX_CONTROL:
        read_mux = timer_control_r;
      `PMT8_IDX_COUNT:
        read_mux = timer_count_r;
      `PMT8_IDX_PERIOD:
        read_mux = period_value_r;
      `PMT8_IDX_STATUS:
        read_mux = status_r;
      `PMT8_IDX_MASK:
        read_mux = mask_r;
      default:
        read_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // the single wait state gives the read mux a full cycle before data must stand
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_r           <= acc;
      avs_waitrequest <= ~acc;
    end
  end

  // read data is captured at the edge that raises the answer and stands through it
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (acc && avs_read)
    begin
      avs_readdata <= {24'h000000, read_mux};
    end
  end

  // ------------------------------------------------------------
  // instruction clock and scalers
  // ------------------------------------------------------------
  // free running divider: writes do not realign it, so tick phase may slip by one
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      instr_div_r <= 2'h0;
    end
    else
    begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      pre_cnt_r <= 4'h0;
    end
    else if (clr_scale)
    begin
      pre_cnt_r <= 4'h0;
    end
    else if (pre_tick)
    begin
      pre_cnt_r <= 4'h0;
    end
    else if (run && instr_en)
    begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end

  // postscaler counts period matches only
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      post_cnt_r <= 4'h0;
    end
    else if (clr_scale)
    begin
      post_cnt_r <= 4'h0;
    end
    else if (post_tick)
    begin
      post_cnt_r <= 4'h0;
    end
    else if (match)
    begin
      post_cnt_r <= post_cnt_r + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      timer_count_r <= `PMT8_COUNT_RST;
    end
    else
    begin
      timer_count_r <= timer_count_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      timer_control_r <= `PMT8_CONTROL_RST;
    end
    else if (wr_ctrl)
    begin
      timer_control_r <= avs_writedata[7:0] & `PMT8_CTRL_WMASK;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      period_value_r <= `PMT8_PERIOD_RST;
    end
    else if (wr_per)
    begin
      period_value_r <= avs_writedata[7:0];
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      mask_r <= `PMT8_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask_r <= avs_writedata[7:0] & (8'h01 << `PMT8_FLAG_BIT);
    end
  end

  // ------------------------------------------------------------
  // status and interrupt
  // ------------------------------------------------------------
  // set wins; a read clears only what it returned, so a later set is never lost
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      status_r <= `PMT8_STATUS_RST;
    end
    else if (post_tick)
    begin
      status_r[`PMT8_FLAG_BIT] <= 1'b1;
    end
    else if (rd_stat)
    begin
      status_r <= status_r & ~avs_readdata[7:0];
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_r & mask_r);
    end
  end

  // ------------------------------------------------------------
  // time base outputs
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      match_pulse     <= 1'b0;
      timer_count_out <= 8'h00;
    end
    else
    begin
      match_pulse     <= match;
      timer_count_out <= timer_count_r;
    end
  end

endmodule

// [verilog/pmt8_consts.vh]
`ifndef PMT8_CONSTS_VH
`define PMT8_CONSTS_VH
// ------------------------------------------------------------
// register word indices (byte address = index * 4)
// ------------------------------------------------------------
`define PMT8_IDX_CONTROL   3'h0
`define PMT8_IDX_COUNT     3'h1
`define PMT8_IDX_PERIOD    3'h2
`define PMT8_IDX_STATUS    3'h3
`define PMT8_IDX_MASK      3'h4
`define PMT8_ADDR_W        5
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PMT8_PRE_LSB       0
`define PMT8_PRE_MSB       1
`define PMT8_RUN_BIT       2
`define PMT8_POST_LSB      3
`define PMT8_POST_MSB      6
`define PMT8_FLAG_BIT      1
`define PMT8_CTRL_WMASK    8'h7F
// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define PMT8_CONTROL_RST   8'h00
`define PMT8_COUNT_RST     8'h00
`define PMT8_PERIOD_RST    8'hFF
`define PMT8_STATUS_RST    8'h00
`define PMT8_MASK_RST      8'h00
`define PMT8_INSTR_DIV     2'h3
`define PMT8_PRE_CODE_4    2'h1
`define PMT8_PRE_TOP_1     4'h0
`define PMT8_PRE_TOP_4     4'h3
`define PMT8_PRE_TOP_16    4'hF
`endif

// [tb/pmt8_timer_chk.sv]
`timescale 1ns/1ps
`include "pmt8_consts.vh"
module pmt8_timer_chk (
  input wire        clk,
  input wire        reset_n,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        irq,
  input wire        match_pulse,
  input wire [7:0]  timer_count_out
);
  // --------------------------------
  // bus and timer checks
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence req_s; $rose(avs_read || avs_write); endsequence
  sequence ack_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
  wire done = avs_read && !avs_waitrequest;
  access_hs_a: assert property (req_s |=> ack_s) else $error("bad handshake");
  match_one_a: assert property (match_pulse |=> !match_pulse) else $error("long match");
  count_step_a: assert property ($changed(timer_count_out) && !$past(avs_write)
    && !$past(avs_write, 2) |-> timer_count_out == $past(timer_count_out) + 8'h01
    || timer_count_out == 8'h00) else $error("bad count step");
  upper_zero_a: assert property (done |-> avs_readdata[31:8] == 24'h0) else $error("upper");
  ctrl_bit7_a: assert property (done && avs_address[4:2] == `PMT8_IDX_CONTROL
    |-> !avs_readdata[7]) else $error("bit7 set");
  unmapped_a: assert property (done && avs_address[4:2] > `PMT8_IDX_MASK
    |-> avs_readdata == 32'h0) else $error("hole data");
  irq_hold_a: assert property (irq && !avs_read && !avs_write && !$past(avs_read)
    && !$past(avs_write) |=> irq) else $error("irq dropped");
  reset_clr_a: assert property ($rose(reset_n) |-> timer_count_out == 8'h00 && !irq)
    else $error("reset state");
endmodule

// [tb/pmt8_timer_bench.sv]
`timescale 1ns/1ps
`include "pmt8_consts.vh"
module pmt8_timer_bench;
  reg         clk = 0, reset_n = 0, rd = 0, wr = 0;
  reg  [4:0]  ad = 0;
  reg  [7:0]  wd = 0;
  reg  [31:0] v;
  wire [31:0] q;
  wire        wt, irq, mp;
  wire [7:0]  cnt;
  int         error_cnt = 0, cmp_count = 0;
  pmt8_timer DUT (.clk(clk), .reset_n(reset_n), .avs_address(ad), .avs_read(rd),
    .avs_write(wr), .avs_writedata({24'h0, wd}), .avs_byteenable(4'hF), .avs_readdata(q),
    .avs_waitrequest(wt), .irq(irq), .match_pulse(mp), .timer_count_out(cnt));
  initial forever #2 clk = ~clk;
  task chk(input string n, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // one request, held until waitrequest is seen low
  task acc(input w, input [2:0] i, input [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    ad <= {i, 2'h0};
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0 && k++ < 40);
    if (wt !== 1'b0) error_cnt++;
    v = q;
    rd <= 0;
    wr <= 0;
  endtask
  task rdc(input string n, input [2:0] i, input [31:0] e);
    acc(0, i, 0);
    chk(n, v, e);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #80000;
    error_cnt++;
    end_sim;
  end
  initial
  begin
    int e;
    repeat (12) @(posedge clk);
    reset_n <= 1;
    rdc("ctl", `PMT8_IDX_CONTROL, 0);
    rdc("cnt", `PMT8_IDX_COUNT, 0);
    rdc("per", `PMT8_IDX_PERIOD, 32'hFF);
    rdc("hole", 3'h6, 0);
    acc(1, `PMT8_IDX_CONTROL, 8'hFB);
    rdc("ctl7", `PMT8_IDX_CONTROL, 32'h7B);
    acc(1, `PMT8_IDX_COUNT, 8'h55);
    acc(1, `PMT8_IDX_CONTROL, 8'h00);
    repeat (100) @(posedge clk);
    rdc("hold", `PMT8_IDX_COUNT, 32'h55);
    $display("register test done");
    acc(1, `PMT8_IDX_PERIOD, 8'h03);
    acc(1, `PMT8_IDX_COUNT, 8'h00);
    acc(1, `PMT8_IDX_MASK, 8'h02);
    acc(1, `PMT8_IDX_CONTROL, 8'h0C);
    repeat (300) if (irq !== 1'b1) @(posedge clk);
    chk("irq", irq, 1);
    acc(1, `PMT8_IDX_CONTROL, 8'h00);
    rdc("flag", `PMT8_IDX_STATUS, 32'h02);
    rdc("clr", `PMT8_IDX_STATUS, 0);
    repeat (4) @(posedge clk);
    chk("irq0", irq, 0);
    $display("flag test done");
    acc(1, `PMT8_IDX_PERIOD, 8'hFF);
    // divider phase is free running, so allow one tick either way
    for (int p = 0; p < 4; p++)
    begin
      acc(1, `PMT8_IDX_CONTROL, {5'h0, 1'b1, p[1:0]});
      acc(1, `PMT8_IDX_COUNT, 8'h00);
      repeat (640) @(posedge clk);
      e = (p == 0) ? 160 : (p == 1) ? 40 : 10;
      chk("pre", (cnt + 1 >= e) && (cnt <= e + 1), 1);
    end
    $display("prescale test done");
    reset_n <= 0;
    repeat (2) @(posedge clk);
    reset_n <= 1;
    rdc("rcnt", `PMT8_IDX_COUNT, 0);
    rdc("rper", `PMT8_IDX_PERIOD, 32'hFF);
    rdc("rctl", `PMT8_IDX_CONTROL, 0);
    $display("reset test done");
    end_sim;
  end
endmodule
bind pmt8_timer pmt8_timer_chk u_chk (.*);
